//--- rtl/rdq_defs.vh
// Constants for the receive done-queue burst writer: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz clock and a byte-addressed host register port.
`ifndef RDQ_DEFS_VH
`define RDQ_DEFS_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define RDQ_OFS_END_INDEX     12'h738
`define RDQ_OFS_READ_PTR      12'h73c
`define RDQ_OFS_WRITE_PTR     12'h740
`define RDQ_OFS_FLUSH_COUNT   12'h744
`define RDQ_OFS_QUEUE_CTRL    12'h780
`define RDQ_OFS_XFER_STATUS   12'h7a0
`define RDQ_OFS_CFG_SELECT    12'h7c0
`define RDQ_OFS_CFG_DATA      12'h7c4

// ------------------------------------------------------------------
// Queue control fields
// ------------------------------------------------------------------
`define RDQ_CTRL_BURST_EN_BIT 4
`define RDQ_CTRL_FLUSH_BIT    5
`define RDQ_CTRL_THR_LSB      8
`define RDQ_CTRL_THR_MSB      10
`define RDQ_CTRL_WMASK        16'h0730

// ------------------------------------------------------------------
// Status fields
// ------------------------------------------------------------------
`define RDQ_STAT_WRITE_BIT    0
`define RDQ_STAT_ERROR_BIT    1

// ------------------------------------------------------------------
// Channel configuration word 2 fields
// ------------------------------------------------------------------
`define RDQ_CFG_CHAN_ON_BIT   0
`define RDQ_CFG_BUFSIZE_LSB   1
`define RDQ_CFG_BUFSIZE_MSB   2
`define RDQ_CFG_THR_LSB       7
`define RDQ_CFG_THR_MSB       9
`define RDQ_CFG_HOST_WORD     2'd2

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define RDQ_RST_FLUSH_COUNT   16'h0000
`define RDQ_RST_QUEUE_CTRL    16'h0000
`define RDQ_RST_END_INDEX     16'h0000
`define RDQ_TICK_DIVIDE       9'd256
`define RDQ_WATERMARK         4'd6

`endif

//--- rtl/rdq_burst_writer.v
// Receive done-queue writer: gathers done descriptors, posts them to the
// circular host done queue, runs the flush timer and holds channel config.
// Assumes the memory write port and descriptor source share this clock.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "rdq_defs.vh"

// Functional notes
// - Eight-entry one-word descriptor buffer.
// - Burst posting waits for six descriptors.
// - Write only what fits before read pointer.
// - No room: error flag, nothing written.
// - Each word advances pointer; threshold sets write flag.
// - Seventeen-bit flush timer, tick per 256 clocks.
// - Timer acts only with burst posting enabled.
// - Timer expiry pushes buffered descriptors out.
// - Every queue write reloads the flush timer.
// - Count one reloads 1, all-ones reloads 65536.
// - Control bit 4 selects burst or single.
// - Control bit 5 flushes all buffered descriptors.
// - Bits 8-10 set status flag write threshold.
// - Config memory 768 words, three per channel.
// - Host writes only lower half of word 2.
// - Word 0 holds current buffer address.
// - Word 1 low half: current descriptor index.
// - Word 1 high half: chain start index.
// - Word 2 bit 0 enables the channel.
// - Word 2 bits 1-2 select buffer sizes.
// - Word 2 bits 7-9 set posting threshold.
// - Pointer past end index wraps to zero.
// - Full when read is one ahead.
module rdq_burst_writer #(
  parameter FIFO_DEPTH = 8,
  parameter CHANNELS   = 256
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [11:0] regAddr,
  input  wire [31:0] regWriteData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regReadData,
  input  wire        descValid,
  input  wire [31:0] descData,
  output wire        descReady,
  output reg         memValid,
  output reg  [15:0] memIndex,
  output reg  [31:0] memData,
  output reg         memLast,
  input  wire        memReady,
  input  wire        cfgUpdWrite,
  input  wire [7:0]  cfgUpdChannel,
  input  wire [1:0]  cfgUpdWord,
  input  wire [31:0] cfgUpdData,
  input  wire [7:0]  cfgLookChannel,
  output reg  [31:0] chanBufAddr,
  output reg  [15:0] chanCurIndex,
  output reg  [15:0] chanStartIndex,
  output reg         chanOn,
  output reg  [1:0]  chanBufSize,
  output reg  [2:0]  chanThreshold
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_BURST = 2'b10;
  localparam CFG_WORDS = CHANNELS * 3;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function [9:0] cfgAddr;
    input [7:0] ch;
    input [1:0] wd;
    begin
      cfgAddr = {1'b0, ch, 1'b0} + {2'b00, ch} + {8'h00, wd};
    end
  endfunction

  reg [15:0] endIndex_reg;

  function [15:0] nextPtr;
    input [15:0] p;
    begin
      if (p >= endIndex_reg)
        nextPtr = 16'h0000;
      else
        nextPtr = p + 16'h0001;
    end
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  reg [15:0] flushCount_reg;
  reg [15:0] queueCtrl_reg;
  reg [15:0] readPtr_reg;
  reg [15:0] writePtr_reg;
  reg [15:0] issuePtr_reg;
  reg        writeFlag_reg;
  reg        errorFlag_reg;
  reg [9:0]  cfgSelect_reg;
  reg [1:0]  state_reg;
  reg [3:0]  burstLeft_reg;
  reg [7:0]  thrCount_reg;
  reg [7:0]  prescale_reg;
  reg [16:0] timer_reg;
  reg [31:0] fifoMem [0:FIFO_DEPTH-1];
  reg [2:0]  fifoRd_reg;
  reg [2:0]  fifoWr_reg;
  reg [3:0]  fifoCount_reg;
  reg [31:0] cfgMem [0:CFG_WORDS-1];

  wire burstEn  = queueCtrl_reg[`RDQ_CTRL_BURST_EN_BIT];
  wire flushReq = queueCtrl_reg[`RDQ_CTRL_FLUSH_BIT];
  wire [2:0] thrCode = queueCtrl_reg[`RDQ_CTRL_THR_MSB:`RDQ_CTRL_THR_LSB];
  wire [8:0] thrTarget = 9'h001 << thrCode;

  // ------------------------------------------------------------------
  // Free space in the circular queue; one slot always stays empty.
  // Room is only judged while idle, so a read pointer that moves
  // during a burst counts from the next burst on.
  // ------------------------------------------------------------------
  wire [16:0] qSize = {1'b0, endIndex_reg} + 17'h00001;
  wire [16:0] used  = (writePtr_reg >= readPtr_reg) ?
                      {1'b0, writePtr_reg - readPtr_reg} :
                      {1'b0, writePtr_reg} + qSize - {1'b0, readPtr_reg};
  wire [16:0] room  = (used + 17'h00001 >= qSize) ? 17'h00000 :
                      qSize - used - 17'h00001;
  wire [3:0]  toSend = (room < {13'h0, fifoCount_reg}) ? room[3:0] : fifoCount_reg;

  // ------------------------------------------------------------------
  // Posting trigger. Single-word mode posts as soon as a descriptor is
  // held; burst mode waits for the watermark, the flush bit or an
  // expired timer.
  // ------------------------------------------------------------------
  wire timerExpired = burstEn && (timer_reg == 17'h00000);
  wire haveData     = (fifoCount_reg != 4'h0);
  wire trigger = haveData && (!burstEn || flushReq || timerExpired ||
                 fifoCount_reg >= `RDQ_WATERMARK);

  wire accept  = memValid && memReady;
  wire canLoad = !memValid || memReady;
  wire loadWord = (state_reg == ST_BURST) && canLoad && (burstLeft_reg != 4'h0);
  wire push = descValid && descReady;

  // A word leaves the buffer when it moves into the output register,
  // so one more descriptor can be taken while the host stalls.
  assign descReady = (fifoCount_reg < FIFO_DEPTH);

  // ------------------------------------------------------------------
  // Descriptor buffer
  // ------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (push)
      fifoMem[fifoWr_reg] <= descData;
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fifoRd_reg    <= 3'h0;
      fifoWr_reg    <= 3'h0;
      fifoCount_reg <= 4'h0;
    end
    else
    begin
      if (push)
        fifoWr_reg <= fifoWr_reg + 3'h1;
      if (loadWord)
        fifoRd_reg <= fifoRd_reg + 3'h1;
      if (push && !loadWord)
        fifoCount_reg <= fifoCount_reg + 4'h1;
      else if (!push && loadWord)
        fifoCount_reg <= fifoCount_reg - 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Burst engine, pointers, status flags and flush timer
  // ------------------------------------------------------------------
  wire statClr = regWrite && (regAddr == `RDQ_OFS_XFER_STATUS);
  // The threshold counter clears whenever the flag is set, so a lower
  // code chosen mid-stream takes effect on the next accepted word.
  wire [7:0] thrCountInc = thrCount_reg + 8'h01;
  wire thrHit = accept && ({1'b0, thrCountInc} >= thrTarget);
  wire noRoom = (state_reg == ST_IDLE) && trigger && (toSend == 4'h0);
  wire [16:0] reload = (flushCount_reg == 16'hffff) ? 17'h10000 :
                       {1'b0, flushCount_reg};

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg     <= ST_IDLE;
      burstLeft_reg <= 4'h0;
      issuePtr_reg  <= 16'h0000;
      writePtr_reg  <= 16'h0000;
      memValid      <= 1'b0;
      memIndex      <= 16'h0000;
      memData       <= 32'h00000000;
      memLast       <= 1'b0;
      thrCount_reg  <= 8'h00;
      writeFlag_reg <= 1'b0;
      errorFlag_reg <= 1'b0;
      prescale_reg  <= 8'h00;
      timer_reg     <= 17'h00000;
    end
    else
    begin
      // Set wins over a same-cycle write-one clear.
      if (thrHit)
        writeFlag_reg <= 1'b1;
      else if (statClr && regWriteData[`RDQ_STAT_WRITE_BIT])
        writeFlag_reg <= 1'b0;
      if (noRoom)
        errorFlag_reg <= 1'b1;
      else if (statClr && regWriteData[`RDQ_STAT_ERROR_BIT])
        errorFlag_reg <= 1'b0;

      if (accept)
      begin
        writePtr_reg <= nextPtr(memIndex);
        thrCount_reg <= thrHit ? 8'h00 : thrCountInc;
      end

      // The timer is held at its reload value while words are going out.
      // The prescaler runs freely, so the first tick after a reload comes
      // anywhere within 256 clocks: the wait is up to 255 clocks short.
      prescale_reg <= prescale_reg + 8'h01;
      if (accept)
        timer_reg <= reload;
      else if (burstEn && prescale_reg == 8'hff && timer_reg != 17'h00000)
        timer_reg <= timer_reg - 17'h00001;

      case (state_reg)
        ST_IDLE:
        begin
          if (trigger && toSend != 4'h0)
          begin
            // Single-word mode takes one descriptor per trip through idle,
            // even when several have piled up behind a full queue.
            if (burstEn)
              burstLeft_reg <= toSend;
            else
              burstLeft_reg <= 4'h1;
            issuePtr_reg  <= writePtr_reg;
            state_reg     <= ST_BURST;
          end
        end
        ST_BURST:
        begin
          if (canLoad)
          begin
            if (burstLeft_reg != 4'h0)
            begin
              memValid      <= 1'b1;
              memData       <= fifoMem[fifoRd_reg];
              memIndex      <= issuePtr_reg;
              memLast       <= (burstLeft_reg == 4'h1);
              issuePtr_reg  <= nextPtr(issuePtr_reg);
              burstLeft_reg <= burstLeft_reg - 4'h1;
            end
            else
            begin
              memValid  <= 1'b0;
              memLast   <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Channel configuration memory. Device and host own disjoint halves
  // of word 2, so a same-cycle write from both merges cleanly.
  // ------------------------------------------------------------------
  wire [9:0] updAddr  = cfgAddr(cfgUpdChannel, cfgUpdWord);
  wire [9:0] lookBase = cfgAddr(cfgLookChannel, 2'd0);
  wire hostCfgWr = regWrite && (regAddr == `RDQ_OFS_CFG_DATA) &&
                   (cfgSelect_reg[9:8] == `RDQ_CFG_HOST_WORD);
  wire [9:0] hostAddr = cfgAddr(cfgSelect_reg[7:0], cfgSelect_reg[9:8]);
  wire updWord2 = (cfgUpdWord == `RDQ_CFG_HOST_WORD);

  always @(posedge clock)
  begin
    if (cfgUpdWrite && cfgUpdWord != 2'd3)
    begin
      if (updWord2)
        cfgMem[updAddr][31:16] <= cfgUpdData[31:16];
      else
        cfgMem[updAddr] <= cfgUpdData;
    end
    if (hostCfgWr)
      cfgMem[hostAddr][15:0] <= regWriteData[15:0];
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chanBufAddr    <= 32'h00000000;
      chanCurIndex   <= 16'h0000;
      chanStartIndex <= 16'h0000;
      chanOn         <= 1'b0;
      chanBufSize    <= 2'b00;
      chanThreshold  <= 3'b000;
    end
    else
    begin
      chanBufAddr    <= cfgMem[lookBase];
      chanCurIndex   <= cfgMem[lookBase + 10'd1][15:0];
      chanStartIndex <= cfgMem[lookBase + 10'd1][31:16];
      chanOn         <= cfgMem[lookBase + 10'd2][`RDQ_CFG_CHAN_ON_BIT];
      chanBufSize    <= cfgMem[lookBase + 10'd2][`RDQ_CFG_BUFSIZE_MSB:`RDQ_CFG_BUFSIZE_LSB];
      chanThreshold  <= cfgMem[lookBase + 10'd2][`RDQ_CFG_THR_MSB:`RDQ_CFG_THR_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Register port. A zero flush count is illegal once burst posting is
  // on; the timer then expires at once and every descriptor is pushed.
  // ------------------------------------------------------------------
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flushCount_reg <= `RDQ_RST_FLUSH_COUNT;
      queueCtrl_reg  <= `RDQ_RST_QUEUE_CTRL;
      endIndex_reg   <= `RDQ_RST_END_INDEX;
      readPtr_reg    <= 16'h0000;
      cfgSelect_reg  <= 10'h000;
      regReadData    <= 32'h00000000;
    end
    else
    begin
      if (regWrite)
      begin
        case (regAddr)
          `RDQ_OFS_FLUSH_COUNT: flushCount_reg <= regWriteData[15:0];
          `RDQ_OFS_QUEUE_CTRL:  queueCtrl_reg  <= regWriteData[15:0] & `RDQ_CTRL_WMASK;
          `RDQ_OFS_END_INDEX:   endIndex_reg   <= regWriteData[15:0];
          `RDQ_OFS_READ_PTR:    readPtr_reg    <= regWriteData[15:0];
          `RDQ_OFS_CFG_SELECT:  cfgSelect_reg  <= regWriteData[9:0];
          default:              readPtr_reg    <= readPtr_reg;
        endcase
      end
      if (regRead)
      begin
        case (regAddr)
          `RDQ_OFS_FLUSH_COUNT: regReadData <= {16'h0000, flushCount_reg};
          `RDQ_OFS_QUEUE_CTRL:  regReadData <= {16'h0000, queueCtrl_reg};
          `RDQ_OFS_END_INDEX:   regReadData <= {16'h0000, endIndex_reg};
          `RDQ_OFS_READ_PTR:    regReadData <= {16'h0000, readPtr_reg};
          `RDQ_OFS_WRITE_PTR:   regReadData <= {16'h0000, writePtr_reg};
          `RDQ_OFS_XFER_STATUS: regReadData <= {30'h0, errorFlag_reg, writeFlag_reg};
          `RDQ_OFS_CFG_SELECT:  regReadData <= {22'h0, cfgSelect_reg};
          `RDQ_OFS_CFG_DATA:    regReadData <= (cfgSelect_reg[9:8] == 2'd3) ? 32'h00000000 : cfgMem[hostAddr];
          default:              regReadData <= 32'h00000000;
        endcase
      end
      else
        regReadData <= 32'h00000000;
    end
  end

endmodule // rdq_burst_writer

//--- test/rdq_burst_writer_assertions.sv
// Checker for the done-queue writer: shadows buffer, pointers, control.
// Assumes software moves the read pointer only while no burst is out.
`timescale 1ns/1ps
module rdq_burst_writer_assertions (
  input wire        clock,
  input wire        reset_n,
  input wire [11:0] regAddr,
  input wire [31:0] regWriteData,
  input wire        regWrite,
  input wire        descValid,
  input wire [31:0] descData,
  input wire        descReady,
  input wire        memValid,
  input wire [15:0] memIndex,
  input wire [31:0] memData,
  input wire        memLast,
  input wire        memReady
);
  reg  [31:0] fifoReg [0:7];
  reg  [2:0]  wrpReg;
  reg  [2:0]  rdpReg;
  reg  [3:0]  cntReg;
  reg  [15:0] wpReg;
  reg  [15:0] rpReg;
  reg  [15:0] endReg;
  reg         burstReg;
  wire        descAcc = descValid & descReady;
  wire        memAcc  = memValid & memReady;
  wire [15:0] nxtIdx  = (memIndex == endReg) ? 16'h0000 : memIndex + 16'h0001;
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrpReg   <= 3'h0;
      rdpReg   <= 3'h0;
      cntReg   <= 4'h0;
      wpReg    <= 16'h0000;
      rpReg    <= 16'h0000;
      endReg   <= 16'h0000;
      burstReg <= 1'b0;
    end
    else
    begin
      if (descAcc)
        fifoReg[wrpReg] <= descData;
      wrpReg <= wrpReg + {2'h0, descAcc};
      rdpReg <= rdpReg + {2'h0, memAcc};
      cntReg <= cntReg + {3'h0, descAcc} - {3'h0, memAcc};
      if (memAcc)
        wpReg <= nxtIdx;
      if (regWrite && regAddr == 12'h73c)
        rpReg <= regWriteData[15:0];
      if (regWrite && regAddr == 12'h738)
        endReg <= regWriteData[15:0];
      if (regWrite && regAddr == 12'h780)
        burstReg <= regWriteData[4];
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ready; descReady == ((cntReg - {3'h0, memValid}) < 4'h8); endproperty
  a_ready: assert property (p_ready) else $error("buffer ready wrong");
  property p_data; memValid |-> memData == fifoReg[rdpReg]; endproperty
  a_data: assert property (p_data) else $error("word out of order");
  property p_ptr; memValid |-> memIndex == wpReg; endproperty
  a_ptr: assert property (p_ptr) else $error("queue index wrong");
  property p_room; memValid |-> nxtIdx != rpReg; endproperty
  a_room: assert property (p_room) else $error("queue overrun");
  property p_single; memValid && !burstReg |-> memLast; endproperty
  a_single: assert property (p_single) else $error("multi-word post");
  property p_hold; memValid && !memReady |=> memValid && $stable(memIndex) && $stable(memData); endproperty
  a_hold: assert property (p_hold) else $error("word dropped in stall");
  property p_last; memAcc && memLast |=> !memValid; endproperty
  a_last: assert property (p_last) else $error("burst overruns");
  property p_nonempty; memValid |-> cntReg != 4'h0; endproperty
  a_nonempty: assert property (p_nonempty) else $error("post from empty buffer");
  cover property (memAcc && memLast && $past(memAcc && !memLast));
  cover property (memValid && !memReady);
  cover property (descAcc && cntReg == 4'h5);
endmodule // rdq_burst_writer_assertions

bind rdq_burst_writer rdq_burst_writer_assertions u_chk (.clock(clock), .reset_n(reset_n),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .descValid(descValid),
  .descData(descData), .descReady(descReady), .memValid(memValid), .memIndex(memIndex),
  .memData(memData), .memLast(memLast), .memReady(memReady));

//--- test/rdq_mem_model.sv
// Host memory model: stores each accepted done-queue word by index.
// Assumes queues of at most 16 entries.
`timescale 1ns/1ps
module rdq_mem_model (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        stall,
  input  wire        memValid,
  input  wire [15:0] memIndex,
  input  wire [31:0] memData,
  output wire        memReady
);
  reg [31:0] store [0:15];
  integer    wordCnt;
  // A stalled host takes nothing, so the writer must hold its word.
  assign memReady = ~stall;
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wordCnt <= 0;
    else if (memValid && memReady)
    begin
      store[memIndex[3:0]] <= memData;
      wordCnt <= wordCnt + 1;
    end
  end
endmodule // rdq_mem_model

//--- test/rdq_tb.sv
// Testbench for the done-queue writer with a host memory model.
// Assumes a 16-entry queue and a flush count of four ticks.
`timescale 1ns/1ps
module tb;
  reg         clock = 1'b0;
  reg         reset_n = 1'b0;
  reg  [11:0] regAddr = 12'h000;
  reg  [31:0] regWriteData = 32'h0;
  reg         regWrite = 1'b0;
  reg         regRead = 1'b0;
  reg         descValid = 1'b0;
  reg  [31:0] descData = 32'h0;
  reg         stall = 1'b0;
  reg         cfgUpdWrite = 1'b0;
  reg  [7:0]  cfgUpdChannel = 8'h00;
  reg  [1:0]  cfgUpdWord = 2'h0;
  reg  [31:0] cfgUpdData = 32'h0;
  reg  [7:0]  cfgLookChannel = 8'h00;
  wire [31:0] regReadData;
  wire        descReady;
  wire        memValid;
  wire [15:0] memIndex;
  wire [31:0] memData;
  wire        memLast;
  wire        memReady;
  wire [31:0] chanBufAddr;
  wire [15:0] chanCurIndex;
  wire [15:0] chanStartIndex;
  wire        chanOn;
  wire [1:0]  chanBufSize;
  wire [2:0]  chanThreshold;
  reg  [31:0] rdv;
  integer     num_errors = 0;
  integer     n_tests = 0;
  integer     seq = 0;
  integer     i;
  always #5 clock = ~clock;
  rdq_burst_writer DUT (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .descValid(descValid),
    .descData(descData), .descReady(descReady), .memValid(memValid), .memIndex(memIndex), .memData(memData),
    .memLast(memLast), .memReady(memReady), .cfgUpdWrite(cfgUpdWrite), .cfgUpdChannel(cfgUpdChannel),
    .cfgUpdWord(cfgUpdWord), .cfgUpdData(cfgUpdData), .cfgLookChannel(cfgLookChannel),
    .chanBufAddr(chanBufAddr), .chanCurIndex(chanCurIndex), .chanStartIndex(chanStartIndex),
    .chanOn(chanOn), .chanBufSize(chanBufSize), .chanThreshold(chanThreshold));
  rdq_mem_model u_mem (.clock(clock), .reset_n(reset_n), .stall(stall), .memValid(memValid),
    .memIndex(memIndex), .memData(memData), .memReady(memReady));
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  end
  endtask
  task rd(input [11:0] a);
  begin
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    rdv = regReadData;
  end
  endtask
  task send;
  begin
    @(posedge clock);
    descValid <= 1'b1;
    descData <= {16'hc0de, seq[15:0]};
    @(negedge clock);
    while (descReady !== 1'b1)
      @(negedge clock);
    @(posedge clock);
    descValid <= 1'b0;
    seq = seq + 1;
  end
  endtask
  // The bound is a limit on the wait, not an expected latency.
  task waitWords(input integer n, input integer lim);
    integer k;
  begin
    k = 0;
    while (u_mem.wordCnt != n && k < lim)
    begin
      @(posedge clock);
      k = k + 1;
    end
    check("words", u_mem.wordCnt, n);
  end
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset;
  begin
    rd(12'h744);
    check("flush count", rdv, 32'h0);
    wr(12'h780, 32'hffff);
    rd(12'h780);
    check("ctrl bits", rdv, 32'h0730);
    wr(12'h780, 32'h0);
    wr(12'h740, 32'h7);
    rd(12'h740);
    check("write ptr", rdv, 32'h0);
    rd(12'h7fc);
    check("unmapped", rdv, 32'h0);
    wr(12'h738, 32'hf);
    wr(12'h744, 32'h4);
    send;
    send;
    waitWords(2, 30);
    rd(12'h7a0);
    check("write flag", rdv, 32'h1);
    wr(12'h7a0, 32'h3);
  end
  endtask
  task t_burst;
  begin
    wr(12'h780, 32'h10);
    repeat (5) send;
    repeat (20) @(posedge clock);
    check("below mark", u_mem.wordCnt, 2);
    stall <= 1'b1;
    send;
    repeat (8) @(posedge clock);
    stall <= 1'b0;
    waitWords(8, 30);
    send;
    send;
    repeat (700) @(posedge clock);
    check("timer early", u_mem.wordCnt, 8);
    waitWords(10, 400);
    send;
    repeat (10) @(posedge clock);
    check("one held", u_mem.wordCnt, 10);
    wr(12'h780, 32'h30);
    waitWords(11, 20);
    wr(12'h780, 32'h10);
  end
  endtask
  task t_room;
  begin
    wr(12'h73c, 32'hc);
    repeat (6) send;
    repeat (20) @(posedge clock);
    check("no room", u_mem.wordCnt, 11);
    rd(12'h7a0);
    check("error flag", rdv & 32'h2, 32'h2);
    rd(12'h740);
    check("ptr kept", rdv, 32'hb);
    wr(12'h73c, 32'he);
    waitWords(13, 30);
    wr(12'h73c, 32'hc);
    wr(12'h780, 32'h30);
    waitWords(17, 30);
    wr(12'h780, 32'h0200);
    rd(12'h740);
    check("wrapped ptr", rdv, 32'h1);
    wr(12'h7a0, 32'h3);
    repeat (3) send;
    waitWords(20, 30);
    rd(12'h7a0);
    check("below thr", rdv, 32'h0);
    send;
    waitWords(21, 30);
    rd(12'h7a0);
    check("at thr", rdv, 32'h1);
    for (i = 0; i < 16; i = i + 1)
      check("queue word", u_mem.store[i], {16'hc0de, (i < 5) ? 16'd16 + i[15:0] : i[15:0]});
    wr(12'h73c, 32'h6);
    send;
    send;
    wr(12'h73c, 32'hc);
    waitWords(23, 30);
    rd(12'h740);
    check("single posts", rdv, 32'h7);
    check("second single", u_mem.store[6], {16'hc0de, 16'd22});
  end
  endtask
  task t_config;
  begin
    @(posedge clock);
    cfgUpdWrite <= 1'b1;
    cfgUpdChannel <= 8'hff;
    cfgUpdData <= 32'h12345678;
    @(posedge clock);
    cfgUpdWord <= 2'h1;
    cfgUpdData <= 32'h00050009;
    @(posedge clock);
    cfgUpdWrite <= 1'b0;
    wr(12'h7c0, 32'h2ff);
    wr(12'h7c4, 32'h0385);
    wr(12'h7c0, 32'h0ff);
    wr(12'h7c4, 32'hffff);
    cfgLookChannel <= 8'hff;
    repeat (2) @(posedge clock);
    #1;
    check("buf addr", chanBufAddr, 32'h12345678);
    check("cur index", chanCurIndex, 32'h9);
    check("start index", chanStartIndex, 32'h5);
    check("chan on", chanOn, 32'h1);
    check("buf size", chanBufSize, 32'h2);
    check("threshold", chanThreshold, 32'h7);
  end
  endtask
  task results;
  begin
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_burst;
    t_room;
    t_config;
    results;
  end
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    results;
  end
endmodule // tb
